// *** rtl/ecpr_pkg.sv ***
// package for the ecp register and fifo block: offsets, fields, modes
// assumes an avalon-mm slave with 32-bit data, word-aligned registers
package ecpr_pkg;

  // byte addresses of our own choosing, one register per word
  localparam logic [5:0] OFF_DATA_PINS   = 6'h00;  // mode 000/001
  localparam logic [5:0] OFF_CMD_FIFO    = 6'h00;  // mode 011 write
  localparam logic [5:0] OFF_STATUS      = 6'h04;
  localparam logic [5:0] OFF_CONTROL     = 6'h08;
  localparam logic [5:0] OFF_FIFO_PORT   = 6'h10;  // compat/data/test by mode
  localparam logic [5:0] OFF_EXT_CONTROL = 6'h14;
  localparam logic [5:0] OFF_FIFO_STAT   = 6'h18;

  localparam int CTL_STROBE_BIT   = 0;
  localparam int CTL_AUTOFEED_BIT = 1;
  localparam int CTL_ACKIRQ_BIT   = 4;
  localparam int CTL_DIR_BIT      = 5;
  localparam int STS_RSVD_BIT     = 2;
  localparam int EXT_MODE_LSB     = 5;

  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] EXT_RST     = 8'h00;

  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW    = 4;

  // peripheral cycle setup delay before the handshake wait, either direction, in cycles
  localparam logic [3:0] RD_SETTLE = 4'h2;

  typedef enum logic [2:0] {
    ECPR_MODE_SPP    = 3'h0,
    ECPR_MODE_BIDIR  = 3'h1,
    ECPR_MODE_COMPAT = 3'h2,
    ECPR_MODE_ECP    = 3'h3,
    ECPR_MODE_R4     = 3'h4,
    ECPR_MODE_R5     = 3'h5,
    ECPR_MODE_TEST   = 3'h6,
    ECPR_MODE_CFG    = 3'h7
  } ecpr_mode_e;

  typedef struct packed {
    logic       cmd;   // 1 = command, 0 = data
    logic [7:0] byte_v;
  } ecpr_entry_s;

  typedef struct packed {
    logic        busy;
    logic        ack_n;
    logic        paper_end;
    logic        select;
    logic        error_n;
  } ecpr_status_s;

endpackage

// *** rtl/ecpr_port.sv ***
// ecp register file and shared fifo of a parallel host port
// assumes avalon-mm master on sys_clk; peripheral pins are asynchronous
// Behaviour
// - data register reads return live data pin levels, not the written latch.
// - forward command port write pushes byte tagged command; reads undefined.
// - backward command port writes are discarded.
// - status register is read-only mirror, bit 2 reserved, writes ignored.
// - control bit 5 selects direction, 0 forward, 1 backward.
// - data pins driven in forward direction, released in backward.
// - direction bit read/write except modes 000 and 010, forced zero.
// - control bit 4 enables ack interrupt; clearing it clears level pending.
// - in modes 010 and 011 strobe is hardware handshake with bit 0.
// - in mode 011 autofeed is hardware handshake with bit 1.
// - compat fifo port write-only, pushes data-tagged bytes.
// - forward data fifo port writes push data-tagged bytes; reads undefined.
// - backward mode runs peripheral reads to fill fifo; reads pop.
// - test fifo port pushes and pops with no peripheral cycle.
// - test port works both directions; forward still drives data pins.
// - test overfill or underrun ignored, no stall, pops stay fifo order.
// - shared fifo holds 16 bytes plus one tag bit each.
// - mode is extended control bits 7..5 and selects reachable fifo port.
// - full writes and empty reads ignored, flags unchanged.
`timescale 1ns/1ns
module ecpr_port
  import ecpr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [7:0]  data_pins_i,
  output logic      [7:0]  data_pins_o,
  output logic             data_pins_oe,
  input  wire logic        busy_i,
  input  wire logic        ack_n_i,
  input  wire logic        paper_end_i,
  input  wire logic        select_i,
  input  wire logic        error_n_i,
  output logic             host_strobe_n,
  output logic             autofeed_line_n,
  output logic             ack_irq
);

  // two-flop synchronisers for all peripheral inputs
  logic [7:0]   pins_s1_r, pins_s2_r;
  ecpr_status_s sts_s1_r, sts_s2_r;
  ecpr_status_s sts_raw;
  assign sts_raw = '{busy: busy_i, ack_n: ack_n_i, paper_end: paper_end_i,
                     select: select_i, error_n: error_n_i};
  always_ff @(posedge sys_clk) begin
    pins_s1_r <= data_pins_i;
    pins_s2_r <= pins_s1_r;
    sts_s1_r  <= sts_raw;
    sts_s2_r  <= sts_s1_r;
  end

  // bus decode; every access answers on the cycle after it is seen
  logic        ack_r;
  logic        rd, wr;
  // writes land at the answer edge, where the master sees waitrequest low
  assign wr = avs_write & ack_r & avs_byteenable[0];
  assign rd = avs_read & ~ack_r;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) ack_r <= 1'b0;
    else         ack_r <= (avs_read | avs_write) & ~ack_r;
  end
  assign avs_waitrequest = ~ack_r;

  logic [7:0] control_r, ext_r, latch_r;
  ecpr_mode_e mode;
  assign mode = ecpr_mode_e'(ext_r[EXT_MODE_LSB +: 3]);
  wire dir_back = control_r[CTL_DIR_BIT];

  wire hit_lo   = avs_address == OFF_DATA_PINS;
  wire hit_ctl  = avs_address == OFF_CONTROL;
  wire hit_fifo = avs_address == OFF_FIFO_PORT;
  wire hit_ext  = avs_address == OFF_EXT_CONTROL;
  wire mode_spp = (mode == ECPR_MODE_SPP) | (mode == ECPR_MODE_BIDIR);
  wire dir_lock = (mode == ECPR_MODE_SPP) | (mode == ECPR_MODE_COMPAT);

  // fifo
  ecpr_entry_s mem [FIFO_DEPTH];
  logic [FIFO_AW:0] wp_r, rp_r;
  wire fifo_empty = wp_r == rp_r;
  wire fifo_full  = (wp_r[FIFO_AW] != rp_r[FIFO_AW]) &
                    (wp_r[FIFO_AW-1:0] == rp_r[FIFO_AW-1:0]);
  ecpr_entry_s head;
  assign head = mem[rp_r[FIFO_AW-1:0]];

  // host pushes per mode and direction
  wire push_cmd  = wr & hit_lo & (mode == ECPR_MODE_ECP) & ~dir_back;
  wire push_cmpt = wr & hit_fifo & (mode == ECPR_MODE_COMPAT);
  wire push_dat  = wr & hit_fifo & (mode == ECPR_MODE_ECP) & ~dir_back;
  wire push_tst  = wr & hit_fifo & (mode == ECPR_MODE_TEST);
  wire pop_host  = rd & hit_fifo &
                   (((mode == ECPR_MODE_ECP) & dir_back) | (mode == ECPR_MODE_TEST));

  // peripheral engine: forward drains fifo, backward fills it
  typedef enum logic [1:0] {ECPR_IDLE, ECPR_SETUP, ECPR_WAIT_ACK, ECPR_DONE} ecpr_st_e;
  ecpr_st_e   st_r, st_nxt;
  logic [3:0] cnt_r;
  logic       hw_strobe_r, hw_feed_r;
  logic [7:0] out_byte_r;
  wire ecp_live = (mode == ECPR_MODE_COMPAT) | (mode == ECPR_MODE_ECP);
  wire fwd_go  = ecp_live & ~dir_back & ~fifo_empty;
  wire back_go = (mode == ECPR_MODE_ECP) & dir_back & ~fifo_full;
  wire handshake_ok = dir_back ? ~sts_s2_r.ack_n : sts_s2_r.busy;
  wire handshake_rel = dir_back ? sts_s2_r.ack_n : ~sts_s2_r.busy;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ECPR_IDLE:     if (fwd_go | back_go) st_nxt = ECPR_SETUP;
      ECPR_SETUP:    if (cnt_r == RD_SETTLE) st_nxt = ECPR_WAIT_ACK;
      ECPR_WAIT_ACK: if (handshake_ok) st_nxt = ECPR_DONE;
      ECPR_DONE:     if (handshake_rel) st_nxt = ECPR_IDLE;
    endcase
    if (!ecp_live) st_nxt = ECPR_IDLE;
  end

  wire eng_pop  = (st_r == ECPR_IDLE) & fwd_go & (st_nxt == ECPR_SETUP);
  wire eng_push = (st_r == ECPR_WAIT_ACK) & dir_back & handshake_ok & ~fifo_full;
  logic       do_push, do_pop;
  ecpr_entry_s push_e;
  // full/empty guards make overfill and underrun silent no-ops
  assign do_push = (push_cmd | push_cmpt | push_dat | push_tst | eng_push) & ~fifo_full;
  assign do_pop  = (pop_host | eng_pop) & ~fifo_empty;
  assign push_e.cmd    = push_cmd;
  assign push_e.byte_v = eng_push ? pins_s2_r : avs_writedata[7:0];

  always_ff @(posedge sys_clk) begin
    if (do_push) mem[wp_r[FIFO_AW-1:0]] <= push_e;
  end

  wire mode_change = wr & hit_ext & (avs_writedata[7:5] != ext_r[7:5]);
  always_ff @(posedge sys_clk) begin
    if (sys_rst || (mode_change && !avs_writedata[6])) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (do_push) wp_r <= wp_r + 1'b1;
      if (do_pop)  rp_r <= rp_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r        <= ECPR_IDLE;
      cnt_r       <= '0;
      hw_strobe_r <= 1'b0;
      hw_feed_r   <= 1'b0;
      out_byte_r  <= '0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= (st_r == ECPR_SETUP) ? cnt_r + 1'b1 : '0;
      if (eng_pop) out_byte_r <= head.byte_v;
      hw_strobe_r <= ~dir_back & (st_nxt == ECPR_WAIT_ACK);
      // backward: autofeed asserted requests a byte, dropped once it arrives
      hw_feed_r   <= dir_back ? (st_nxt == ECPR_SETUP) | (st_nxt == ECPR_WAIT_ACK)
                              : (eng_pop & head.cmd) | (hw_feed_r & (st_nxt != ECPR_IDLE));
    end
  end

  // control and extended control registers
  logic [7:0] ctl_wdata;
  always_comb begin
    ctl_wdata = avs_writedata[7:0];
    if (dir_lock) ctl_wdata[CTL_DIR_BIT] = 1'b0;
  end
  wire ext_write = wr & hit_ext;
  logic [2:0] new_mode;
  assign new_mode = avs_writedata[7:5];
  wire new_lock = (new_mode == 3'h0) | (new_mode == 3'h2);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      control_r <= CONTROL_RST;
      ext_r     <= EXT_RST;
      latch_r   <= '0;
    end else begin
      if (wr & hit_ctl) control_r <= ctl_wdata;
      else if (ext_write & new_lock) control_r[CTL_DIR_BIT] <= 1'b0;
      if (ext_write) ext_r <= avs_writedata[7:0];
      if (wr & hit_lo & mode_spp) latch_r <= avs_writedata[7:0];
    end
  end

  // ack deassertion interrupt, level style; masking clears the pending request
  logic ack_prev_r, ack_pend_r;
  wire ack_rise = sts_s2_r.ack_n & ~ack_prev_r;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ack_prev_r <= 1'b1;
      ack_pend_r <= 1'b0;
    end else begin
      ack_prev_r <= sts_s2_r.ack_n;
      if (!control_r[CTL_ACKIRQ_BIT]) ack_pend_r <= 1'b0;
      else if (ack_rise) ack_pend_r <= 1'b1;
      else if (rd && avs_address == OFF_STATUS) ack_pend_r <= 1'b0;
    end
  end

  // readback
  logic [7:0] status_byte;
  assign status_byte = {~sts_s2_r.busy, sts_s2_r.ack_n, sts_s2_r.paper_end,
                        sts_s2_r.select, sts_s2_r.error_n, 1'b0, 2'b11};
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    unique case (avs_address)
      OFF_DATA_PINS:   rd_mux = pins_s2_r;
      OFF_STATUS:      rd_mux = status_byte;
      OFF_CONTROL:     rd_mux = {2'b11, control_r[5:0]};
      OFF_FIFO_PORT:   rd_mux = pop_host ? head.byte_v : 8'h00;
      OFF_EXT_CONTROL: rd_mux = {ext_r[7:2], fifo_full, fifo_empty};
      OFF_FIFO_STAT:   rd_mux = {7'h00, head.cmd};
      default:         rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) avs_readdata <= '0;
    else if (rd) avs_readdata <= {24'h000000, rd_mux};
  end

  // pin outputs from flops
  wire sw_strobe = control_r[CTL_STROBE_BIT];
  wire sw_feed   = control_r[CTL_AUTOFEED_BIT];
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      data_pins_o     <= '0;
      data_pins_oe    <= 1'b1;
      host_strobe_n   <= 1'b1;
      autofeed_line_n <= 1'b1;
      ack_irq         <= 1'b0;
    end else begin
      data_pins_oe    <= ~dir_back;
      data_pins_o     <= mode_spp ? latch_r : out_byte_r;
      host_strobe_n   <= ((mode == ECPR_MODE_COMPAT) | (mode == ECPR_MODE_ECP))
                         ? ~(hw_strobe_r | sw_strobe) : ~sw_strobe;
      autofeed_line_n <= (mode == ECPR_MODE_ECP) ? ~(hw_feed_r | sw_feed)
                         : ~sw_feed;
      ack_irq         <= ack_pend_r;
    end
  end

  // fifo never pops when empty nor pushes when full
  property p_no_overrun;
    @(posedge sys_clk) disable iff (sys_rst)
      fifo_full && !do_pop && !mode_change |=> wp_r == $past(wp_r);
  endproperty
  a_no_overrun: assert property (p_no_overrun) else $error("push into full fifo");

  property p_empty_read;
    @(posedge sys_clk) disable iff (sys_rst)
      fifo_empty && !do_push && !mode_change |=> rp_r == $past(rp_r);
  endproperty
  a_empty_read: assert property (p_empty_read) else $error("pop from empty fifo");

  property p_dir_forced;
    @(posedge sys_clk) disable iff (sys_rst)
      dir_lock && !ext_write |=> !control_r[CTL_DIR_BIT];
  endproperty
  a_dir_forced: assert property (p_dir_forced) else $error("direction set in locked mode");

  property p_oe_dir;
    @(posedge sys_clk) disable iff (sys_rst)
      ##1 data_pins_oe == !$past(control_r[CTL_DIR_BIT]);
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("pin drive disagrees with direction");

  property p_back_cmd_drop;
    @(posedge sys_clk) disable iff (sys_rst)
      wr && hit_lo && dir_back && !eng_push |=> wp_r == $past(wp_r);
  endproperty
  a_back_cmd_drop: assert property (p_back_cmd_drop) else $error("backward command pushed");

  property p_cmd_tag;
    @(posedge sys_clk) disable iff (sys_rst)
      push_cmd && !fifo_full |=> mem[$past(wp_r[FIFO_AW-1:0])].cmd;
  endproperty
  a_cmd_tag: assert property (p_cmd_tag) else $error("command byte not tagged");

  property p_mask_clears;
    @(posedge sys_clk) disable iff (sys_rst)
      !control_r[CTL_ACKIRQ_BIT] |=> ##1 !ack_irq;
  endproperty
  a_mask_clears: assert property (p_mask_clears) else $error("masked ack still pending");

  property p_answer;
    @(posedge sys_clk) disable iff (sys_rst)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");

endmodule

// *** test/ecpr_periph.sv ***
// far-side peripheral model: takes forward bytes on strobe/busy and
// sources backward bytes on autofeed/ack; assumes oe high while port drives
`timescale 1ns/1ns
module ecpr_periph (
  input  wire logic       clk,
  input  wire logic       stall,
  input  wire logic [7:0] pins_o,
  input  wire logic       pins_oe,
  input  wire logic       strobe_n,
  input  wire logic       feed_n,
  output logic      [7:0] pins_i,
  output logic            busy,
  output logic            ack_n
);
  logic [7:0] got_q[$];
  logic [7:0] sent_q[$];
  logic [7:0] drv;
  logic       drv_en;
  // released bus shows the inverse byte so stale data never passes
  assign pins_i = pins_oe ? pins_o : (drv_en ? drv : ~drv);
  initial begin
    busy = 1'b0;
    ack_n = 1'b1;
    drv = 8'h00;
    drv_en = 1'b0;
  end
  always @(posedge clk) begin
    // stall keeps busy low: the slow printer case
    if (!strobe_n && !busy && !stall) begin
      got_q.push_back(pins_i);
      busy <= 1'b1;
    end else if (strobe_n) begin
      busy <= 1'b0;
    end
    // data a cycle ahead of ack so it settles before the port samples
    if (!feed_n && !drv_en && !pins_oe) begin
      drv <= $urandom;
      drv_en <= 1'b1;
    end else if (!feed_n && drv_en && ack_n) begin
      ack_n <= 1'b0;
      sent_q.push_back(drv);
    end else if (feed_n && !ack_n) begin
      ack_n <= 1'b1;
      drv_en <= 1'b0;
    end
  end
endmodule

// *** test/ecp_register_fifo_access_bench.sv ***
// self-checking bench for ecpr_port: registers, fifo ports, peripheral traffic
// assumes ecpr_periph on the far side; this module is the avalon master
`timescale 1ns/1ns
module ecp_register_fifo_access_bench import ecpr_pkg::*;;
  logic        sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest, stall;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0]  pins_o, pins_i, d;
  logic        oe, busy, ack_n, pe, sel, err_n, stb_n, feed_n, ack_irq;
  logic [7:0]  exp_q[$];
  int          n_errors, total_checks, i, base;

  ecpr_port DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .data_pins_i(pins_i), .data_pins_o(pins_o), .data_pins_oe(oe), .busy_i(busy),
    .ack_n_i(ack_n), .paper_end_i(pe), .select_i(sel), .error_n_i(err_n),
    .host_strobe_n(stb_n), .autofeed_line_n(feed_n), .ack_irq(ack_irq));
  ecpr_periph per (.clk(sys_clk), .stall(stall), .pins_o(pins_o), .pins_oe(oe),
    .strobe_n(stb_n), .feed_n(feed_n), .pins_i(pins_i), .busy(busy), .ack_n(ack_n));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] v);
    int k;
    avs_address <= a;
    avs_writedata <= {24'h0, v};
    avs_write <= w;
    avs_read <= !w;
    for (k = 0; k < 50; k++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (k == 50) begin
      n_errors++;
      final_report();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  function automatic logic [31:0] st_exp();
    return {24'h0, ~busy, ack_n, pe, sel, err_n, 3'h3};
  endfunction

  // wait for n new bytes at the peripheral, then compare in order
  task automatic drain(input int n);
    int k;
    for (k = 0; k < 3000 && per.got_q.size() < base + n; k++) @(posedge sys_clk);
    if (per.got_q.size() < base + n) begin
      n_errors++;
      final_report();
    end
    for (k = 0; k < n; k++) chk("periph byte", exp_q[k], per.got_q[base + k]);
    base = base + n;
    exp_q.delete();
  endtask

  initial begin
    void'($urandom(90281));
    {avs_read, avs_write, stall, pe, sel, err_n} = 6'h07;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    n_errors = 0;
    total_checks = 0;
    base = 0;
    sys_rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    bus(0, OFF_CONTROL, 8'h00);
    chk("control reset", 32'hC0, q);
    bus(0, OFF_EXT_CONTROL, 8'h00);
    chk("ext reset", 32'h01, q);
    d = $urandom;
    bus(1, OFF_DATA_PINS, d);
    // latch, pin flop and two sync flops before the read sees it
    repeat (4) @(posedge sys_clk);
    bus(0, OFF_DATA_PINS, 8'h00);
    chk("pins forward", {24'h0, d}, q);
    chk("oe forward", 1'b1, oe);
    bus(1, OFF_CONTROL, 8'h20);
    bus(0, OFF_CONTROL, 8'h00);
    chk("dir mode 000", 32'hC0, q);
    bus(1, OFF_EXT_CONTROL, 8'h20);
    bus(1, OFF_CONTROL, 8'h20);
    bus(0, OFF_CONTROL, 8'h00);
    chk("dir mode 001", 32'hE0, q);
    repeat (3) @(posedge sys_clk);
    chk("oe backward", 1'b0, oe);
    bus(0, OFF_DATA_PINS, 8'h00);
    chk("pins backward", {24'h0, pins_i}, q);
    {pe, sel, err_n} <= 3'($urandom);
    repeat (4) @(posedge sys_clk);
    bus(0, OFF_STATUS, 8'h00);
    chk("status", st_exp(), q);
    bus(1, OFF_STATUS, 8'hFF);
    bus(0, OFF_STATUS, 8'h00);
    chk("status after write", st_exp(), q);
    // backward ecp: hardware fills the fifo, stray writes must not land
    bus(1, OFF_CONTROL, 8'h30);
    bus(1, OFF_EXT_CONTROL, 8'h60);
    bus(1, OFF_CMD_FIFO, 8'hEE);
    bus(1, OFF_FIFO_PORT, 8'hDD);
    for (i = 0; i < 1000 && per.sent_q.size() < 16; i++) @(posedge sys_clk);
    if (per.sent_q.size() < 16) begin
      n_errors++;
      final_report();
    end
    chk("ack irq", 1'b1, ack_irq);
    for (i = 0; i < 16; i++) begin
      bus(0, OFF_FIFO_PORT, 8'h00);
      chk("backward pop", {24'h0, per.sent_q[i]}, q);
    end
    bus(1, OFF_CONTROL, 8'h20);
    repeat (3) @(posedge sys_clk);
    chk("ack irq cleared", 1'b0, ack_irq);
    bus(1, OFF_EXT_CONTROL, 8'h20);
    bus(1, OFF_CONTROL, 8'h00);
    // test fifo: overfill and underrun both ignored, order kept
    bus(1, OFF_EXT_CONTROL, 8'hC0);
    base = per.got_q.size();
    for (i = 0; i < 17; i++) begin
      d = $urandom;
      bus(1, OFF_FIFO_PORT, d);
      if (i < 16) exp_q.push_back(d);
    end
    bus(0, OFF_EXT_CONTROL, 8'h00);
    chk("test full", 32'h2, q & 32'h3);
    chk("test oe", 1'b1, oe);
    for (i = 0; i < 17; i++) begin
      bus(0, OFF_FIFO_PORT, 8'h00);
      if (i < 16) chk("test pop", {24'h0, exp_q[i]}, q);
    end
    bus(0, OFF_EXT_CONTROL, 8'h00);
    chk("test empty", 32'h1, q & 32'h3);
    chk("no periph cycle", base, per.got_q.size());
    exp_q.delete();
    // compat port against a stalled printer, then released
    bus(1, OFF_EXT_CONTROL, 8'h20);
    stall <= 1'b1;
    bus(1, OFF_EXT_CONTROL, 8'h40);
    for (i = 0; i < 20; i++) begin
      bus(0, OFF_EXT_CONTROL, 8'h00);
      d = $urandom;
      bus(1, OFF_FIFO_PORT, d);
      if (!q[1]) exp_q.push_back(d);
    end
    stall <= 1'b0;
    drain(exp_q.size());
    // forward ecp: command and data ports share the fifo in order
    bus(1, OFF_EXT_CONTROL, 8'h20);
    bus(1, OFF_EXT_CONTROL, 8'h60);
    for (i = 0; i < 6; i++) begin
      d = $urandom;
      bus(1, i[0] ? OFF_FIFO_PORT : OFF_CMD_FIFO, d);
      exp_q.push_back(d);
    end
    drain(6);
    final_report();
  end
endmodule
